// >>> core/bfs_top.sv
// bfs_top: boot-time image loader, flash master or serial slave
// assumes: pins arrive asynchronous to clock_i; command port is on clock_i
`timescale 1ns/10ps
// Function
// - strap high at start-up selects slave boot over the serial port.
// - strap low on flash line 1 at start-up selects quad flash master boot.
// - boot runs at start-up and again after every reset event.
// - slave boot takes clock, select, data in; drives data out.
// - flash holds 8192 pages of 256 bytes.
// - every flash address is sent as three bytes.
// - identify with 0x9F, read three id bytes, no dummy.
// - erase in uniform 4 kB sectors with opcode 0x20.
// - write enable is 0x06, write disable is 0x04.
// - page program uses opcode 0x02.
// - bulk read uses 0xEB, one dummy byte after the address.
// - read flash status with opcode 0x05.
// - flash busy while status and 0x01 is nonzero.
// - write flash status with opcode 0x01.
// - upgrade commands only when a flash with image is present.
// - an unfinished upgrade boots the factory image; retry stays possible.
// - upgrades can be removed; next boot then loads the factory image.
// - power-on reset holds everything until supplies are up.
// - master boot starts with a read at address zero.
// - quad link moves each byte low nibble first.
// - slave boot bytes arrive least significant bit first.
module bfs_top #(
  parameter int IMAGE_BYTES = 65536
) (
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // power-on and reset pin
  input wire logic supply_good_i,
  input wire logic reset_pin_n_i,
  // flash link
  output logic flash_clk_o,
  output logic flash_cs_n_o,
  input wire logic flash_data_line_0_i,
  input wire logic flash_data_line_1_i,
  input wire logic flash_data_line_2_i,
  input wire logic flash_data_line_3_i,
  output logic flash_data_line_0_o,
  output logic flash_data_line_1_o,
  output logic flash_data_line_2_o,
  output logic flash_data_line_3_o,
  output logic flash_data_line_0_oe_n_o,
  output logic flash_data_line_1_oe_n_o,
  output logic flash_data_line_2_oe_n_o,
  output logic flash_data_line_3_oe_n_o,
  // slave boot link
  input wire logic spi_clk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  // command port
  input wire logic cmd_valid_i,
  input wire bfs_pkg::bfs_cmd_type cmd_i,
  output logic cmd_ready_o,
  // image stream
  output logic image_valid_o,
  output logic [bfs_pkg::DATA_W-1:0] image_data_o,
  input wire logic image_ready_i,
  // status
  output bfs_pkg::bfs_status_type status_o,
  output logic [23:0] flash_id_o
);
  import bfs_pkg::*;

  typedef enum logic [3:0] {
    ST_POR, ST_STRAP, ST_SLAVE, ST_ID, ST_DIR, ST_LOAD,
    ST_IDLE, ST_WREN, ST_OP, ST_POLL, ST_WRDI
  } bfs_state_type;
  typedef enum logic [2:0] {
    PH_IDLE, PH_OP, PH_ADDR, PH_DUMMY, PH_DATA, PH_GAP
  } bfs_phase_type;

  // pin synchronisers
  logic [8:0] pin_meta;
  logic [8:0] pin_sync;
  logic spi_clk_prev;
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
      spi_clk_prev <= 1'b0;
    end else if (ce_i) begin
      pin_meta <= {supply_good_i, reset_pin_n_i, flash_data_line_3_i,
                   flash_data_line_2_i, flash_data_line_1_i,
                   flash_data_line_0_i, spi_clk_i, spi_cs_n_i, spi_mosi_i};
      pin_sync <= pin_meta;
      spi_clk_prev <= pin_sync[2];
    end
  end
  wire logic [3:0] fl_in = pin_sync[6:3];
  wire logic sl_mosi = pin_sync[0];
  wire logic sl_cs_n = pin_sync[1];
  wire logic sl_rise = pin_sync[2] && !spi_clk_prev;
  // supply not up or reset pin low restarts the boot
  wire logic boot_rst = !pin_sync[8] || !pin_sync[7];

  bfs_state_type state;
  bfs_phase_type ph;
  bfs_cmd_type cmd;
  bfs_xfer_type xf;
  bfs_xfer_type desc;
  logic issued;
  logic [2:0] phase;
  logic [2:0] bit_cnt;
  logic [1:0] byte_cnt;
  logic [CNT_W-1:0] data_left;
  logic [7:0] shreg;
  logic [7:0] rx;
  logic rx_strobe;
  logic [7:0] rx_byte;
  logic slave_mode;
  logic upgrade;
  logic flash_ok;
  logic busy;
  logic [7:0] sl_sh;
  logic [2:0] sl_cnt;
  logic sl_strobe;
  logic [7:0] sl_byte;
  logic sl_seen;
  logic overrun;
  logic boot_done;

  // transaction chosen by the boot and command sequence
  wire logic [23:0] image_base = upgrade ? UPGRADE_BASE : FACTORY_BASE;
  wire logic [23:0] sector_addr = cmd.addr & SECTOR_MASK;
  wire logic cmd_is_erase = cmd.op == CMD_ERASE || cmd.op == CMD_REMOVE;
  wire logic [23:0] op_addr = (cmd.op == CMD_REMOVE) ? DIR_ADDR : sector_addr;
  wire logic [7:0] op_code =
    (cmd.op == CMD_PROGRAM) ? OP_PAGE_PROG :
    (cmd.op == CMD_WRITE_STATUS) ? OP_WRITE_STATUS :
    OP_SECTOR_ERASE;
  always_comb begin
    desc = '0;
    unique case (state)
      ST_ID: begin
        desc.op = OP_READ_ID;
        desc.count = CNT_W'(ID_BYTES);
      end
      ST_DIR: begin
        desc = '{OP_QUAD_READ, 1'b1, DIR_ADDR, 1'b1, 1'b1, 1'b0, 8'h00,
                 CNT_W'(1)};
      end
      ST_LOAD: begin
        desc = '{OP_QUAD_READ, 1'b1, image_base, 1'b1, 1'b1, 1'b0, 8'h00,
                 CNT_W'(IMAGE_BYTES)};
      end
      ST_WREN: desc.op = OP_WRITE_EN;
      ST_WRDI: desc.op = OP_WRITE_DIS;
      ST_POLL: begin
        desc.op = OP_READ_STATUS;
        desc.count = CNT_W'(1);
      end
      ST_OP: begin
        desc.op = op_code;
        desc.addr_en = cmd.op != CMD_WRITE_STATUS;
        desc.addr = cmd_is_erase ? op_addr : cmd.addr;
        desc.tx_en = !cmd_is_erase;
        desc.tx = cmd.data;
        desc.count = cmd_is_erase ? '0 : CNT_W'(1);
      end
      default: desc = '0;
    endcase
  end

  // serial engine: one beat is eight clocks, clock high in the upper half
  wire logic flash_state = state inside {ST_ID, ST_DIR, ST_LOAD, ST_WREN,
                                         ST_OP, ST_POLL, ST_WRDI};
  wire logic go = flash_state && !issued && ph == PH_IDLE;
  wire logic quad_now = xf.quad && ph != PH_OP;
  wire logic last_beat = quad_now ? bit_cnt == 3'h1 : bit_cnt == 3'h7;
  wire logic rx_phase = ph == PH_DATA && !xf.tx_en;
  wire logic fifo_in_ready;
  wire logic stall = rx_phase && state == ST_LOAD && bit_cnt == '0 &&
                     phase == '0 && (!fifo_in_ready || rx_strobe);
  wire logic beat_end = ph != PH_IDLE && phase == BEAT_END_PHASE;
  wire logic byte_end = beat_end && ph != PH_GAP && last_beat;
  wire logic addr_last = byte_cnt == 2'(ADDR_BYTES - 1);
  wire logic dummy_last = byte_cnt == 2'(QREAD_DUMMY_BYTES - 1);
  wire logic [7:0] rx_new = quad_now ? {fl_in, rx[7:4]}
                                     : {rx[6:0], fl_in[1]};
  wire logic [7:0] addr_next = (byte_cnt == 2'h0) ? xf.addr[15:8]
                                                  : xf.addr[7:0];
  wire bfs_phase_type after_addr =
    xf.dummy ? PH_DUMMY : (xf.count != '0) ? PH_DATA : PH_GAP;

  always_ff @(posedge clock_i) begin
    if (rst_i || boot_rst) begin
      ph <= PH_IDLE;
      phase <= '0;
      xf <= '0;
    end else if (ce_i) begin
      if (go) begin
        xf <= desc;
        ph <= PH_OP;
        phase <= '0;
      end else if (ph != PH_IDLE && !stall) begin
        phase <= phase + 3'h1;
        if (ph == PH_GAP && beat_end) begin
          ph <= PH_IDLE;
        end else if (byte_end) begin
          unique case (ph)
            PH_OP: ph <= xf.addr_en ? PH_ADDR : after_addr;
            PH_ADDR: ph <= addr_last ? after_addr : PH_ADDR;
            PH_DUMMY: ph <= dummy_last ? PH_DATA : PH_DUMMY;
            PH_DATA: ph <= (data_left == CNT_W'(1)) ? PH_GAP : PH_DATA;
            default: ph <= ph;
          endcase
        end
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i || boot_rst) begin
      bit_cnt <= '0;
      byte_cnt <= '0;
      data_left <= '0;
      shreg <= '0;
      rx <= '0;
    end else if (ce_i) begin
      if (go) begin
        shreg <= desc.op;
        bit_cnt <= '0;
        byte_cnt <= '0;
        data_left <= desc.count;
      end else if (beat_end && !stall && ph != PH_GAP) begin
        bit_cnt <= last_beat ? '0 : bit_cnt + 3'h1;
        rx <= rx_new;
        shreg <= quad_now ? {4'h0, shreg[7:4]} : {shreg[6:0], 1'b0};
        if (last_beat) begin
          byte_cnt <= (ph == PH_OP || (ph == PH_ADDR && addr_last))
                      ? '0 : byte_cnt + 2'h1;
          if (ph == PH_OP) begin
            shreg <= xf.addr_en ? xf.addr[23:16] : xf.tx;
          end else if (ph == PH_ADDR) begin
            shreg <= addr_last ? xf.tx : addr_next;
          end else if (ph == PH_DATA) begin
            data_left <= data_left - CNT_W'(1);
          end
        end
      end
    end
  end

  // pins, registered from engine state
  wire logic drive_all = quad_now && ph == PH_ADDR;
  wire logic drive_d0 = ph == PH_OP || ph == PH_ADDR ||
                        (ph == PH_DATA && xf.tx_en);
  wire logic [3:0] dout = quad_now ? shreg[3:0] : {3'h0, shreg[7]};
  wire logic sel = ph inside {PH_OP, PH_ADDR, PH_DUMMY, PH_DATA};
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      flash_clk_o <= 1'b0;
      flash_cs_n_o <= 1'b1;
      {flash_data_line_3_o, flash_data_line_2_o, flash_data_line_1_o,
       flash_data_line_0_o} <= '0;
      {flash_data_line_3_oe_n_o, flash_data_line_2_oe_n_o,
       flash_data_line_1_oe_n_o, flash_data_line_0_oe_n_o} <= 4'hF;
    end else if (ce_i) begin
      flash_clk_o <= sel && phase >= SCK_HIGH_PHASE;
      flash_cs_n_o <= !sel;
      {flash_data_line_3_o, flash_data_line_2_o, flash_data_line_1_o,
       flash_data_line_0_o} <= dout;
      {flash_data_line_3_oe_n_o, flash_data_line_2_oe_n_o,
       flash_data_line_1_oe_n_o, flash_data_line_0_oe_n_o} <=
        ~{drive_all, drive_all, drive_all, drive_d0};
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      rx_strobe <= 1'b0;
      rx_byte <= '0;
    end else if (ce_i) begin
      rx_strobe <= byte_end && rx_phase && !stall;
      rx_byte <= rx_new;
    end
  end

  // boot and command sequence
  wire logic eng_done = issued && ph == PH_IDLE;
  wire logic cmd_take = cmd_valid_i && cmd_ready_o;
  wire logic cmd_fits = {1'b0, cmd_i.addr} < FLASH_BYTES;
  wire logic id_ok = flash_id_o != '0 && flash_id_o != ID_BLANK;
  always_ff @(posedge clock_i) begin
    if (rst_i || boot_rst) begin
      state <= ST_POR;
      issued <= 1'b0;
      cmd <= '0;
      busy <= 1'b0;
    end else if (ce_i) begin
      if (go) begin
        issued <= 1'b1;
      end else if (eng_done) begin
        issued <= 1'b0;
      end
      if (state == ST_POLL && rx_strobe) begin
        busy <= (rx_byte & STATUS_BUSY_MASK) != '0;
      end
      unique case (state)
        ST_POR: state <= ST_STRAP;
        ST_STRAP: state <= fl_in[1] ? ST_SLAVE : ST_ID;
        ST_SLAVE: state <= ST_SLAVE;
        ST_ID: state <= eng_done ? ST_DIR : ST_ID;
        ST_DIR: state <= eng_done ? ST_LOAD : ST_DIR;
        ST_LOAD: state <= eng_done ? ST_IDLE : ST_LOAD;
        ST_IDLE: begin
          if (cmd_take && cmd_fits) begin
            cmd <= cmd_i;
            state <= (cmd_i.op == CMD_WRITE_STATUS) ? ST_OP : ST_WREN;
          end
        end
        ST_WREN: state <= eng_done ? ST_OP : ST_WREN;
        ST_OP: state <= eng_done ? ST_POLL : ST_OP;
        ST_POLL: state <= eng_done ? (busy ? ST_POLL : ST_WRDI)
                                   : ST_POLL;
        ST_WRDI: state <= eng_done ? ST_IDLE : ST_WRDI;
        default: state <= ST_POR;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i || boot_rst) begin
      slave_mode <= 1'b0;
      upgrade <= 1'b0;
      flash_ok <= 1'b0;
      flash_id_o <= '0;
      cmd_ready_o <= 1'b0;
    end else if (ce_i) begin
      if (state == ST_STRAP) begin
        slave_mode <= fl_in[1];
      end
      if (state == ST_ID && rx_strobe) begin
        flash_id_o <= {flash_id_o[15:0], rx_byte};
      end
      if (state == ST_DIR) begin
        flash_ok <= id_ok;
      end
      if (state == ST_DIR && rx_strobe) begin
        upgrade <= rx_byte == UPGRADE_MARK;
      end
      cmd_ready_o <= state == ST_IDLE && !cmd_take && flash_ok;
    end
  end

  // slave boot receiver
  always_ff @(posedge clock_i) begin
    if (rst_i || boot_rst) begin
      sl_sh <= '0;
      sl_cnt <= '0;
      sl_strobe <= 1'b0;
      sl_byte <= '0;
      sl_seen <= 1'b0;
      overrun <= 1'b0;
      spi_miso_o <= 1'b0;
    end else if (ce_i) begin
      sl_strobe <= 1'b0;
      if (state != ST_SLAVE || sl_cs_n) begin
        sl_cnt <= '0;
      end else if (sl_rise) begin
        sl_sh <= {sl_mosi, sl_sh[7:1]};
        sl_cnt <= sl_cnt + 3'h1;
        if (sl_cnt == 3'h7) begin
          sl_strobe <= 1'b1;
          sl_byte <= {sl_mosi, sl_sh[7:1]};
          sl_seen <= 1'b1;
        end
      end
      if (sl_strobe && !fifo_in_ready) begin
        overrun <= 1'b1;
      end
      spi_miso_o <= overrun;
    end
  end

  // image FIFO and output stage
  wire logic fifo_in_valid = (state == ST_LOAD && rx_strobe) || sl_strobe;
  wire logic [7:0] fifo_in_data = slave_mode ? sl_byte : rx_byte;
  wire logic fifo_out_valid;
  wire logic [7:0] fifo_out_data;
  wire logic out_take = !image_valid_o || image_ready_i;
  bfs_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock_i(clock_i),
    .rst_i(rst_i || boot_rst),
    .ce_i(ce_i),
    .in_valid_i(fifo_in_valid),
    .in_data_i(fifo_in_data),
    .in_ready_o(fifo_in_ready),
    .out_valid_o(fifo_out_valid),
    .out_data_o(fifo_out_data),
    .out_ready_i(out_take)
  );

  always_ff @(posedge clock_i) begin
    if (rst_i || boot_rst) begin
      image_valid_o <= 1'b0;
      image_data_o <= '0;
      boot_done <= 1'b0;
      status_o <= '0;
    end else if (ce_i) begin
      if (out_take) begin
        image_valid_o <= fifo_out_valid;
        image_data_o <= fifo_out_data;
      end
      if ((state == ST_LOAD && eng_done) ||
          (state == ST_SLAVE && sl_seen && sl_cs_n)) begin
        boot_done <= 1'b1;
      end
      status_o <= '{boot_done, slave_mode, upgrade, flash_ok, overrun};
    end
  end

  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);

  AST_SLAVE_STRAP: assert property (
    ce_i && !boot_rst && state == ST_STRAP && fl_in[1]
    |=> state == ST_SLAVE && slave_mode)
    else $error("high strap did not select slave boot");
  AST_MASTER_STRAP: assert property (
    ce_i && !boot_rst && state == ST_STRAP && !fl_in[1]
    |=> state == ST_ID ##1 ce_i [*8] ##0 !flash_cs_n_o)
    else $error("low strap did not start flash identify");
  AST_RESTART: assert property (
    boot_rst |=> state == ST_POR && !status_o.boot_done ##0 issued == 1'b0)
    else $error("reset event did not restart the boot");
  AST_SLAVE_PINS: assert property (
    slave_mode && $past(slave_mode) |-> flash_cs_n_o &&
    flash_data_line_0_oe_n_o && flash_data_line_1_oe_n_o &&
    flash_data_line_2_oe_n_o && flash_data_line_3_oe_n_o)
    else $error("flash pins driven during slave boot");
  AST_ADDR_LEN: assert property (
    ce_i && ph == PH_ADDR && byte_end && !stall && addr_last
    |=> ph != PH_ADDR)
    else $error("address phase not three bytes");
  AST_DIR_ZERO: assert property (
    $rose(state == ST_DIR) |-> ##[1:4] (ph == PH_OP && xf.addr == DIR_ADDR
    && xf.op == OP_QUAD_READ))
    else $error("boot read did not start at address zero");
  AST_BUSY_POLL: assert property (
    ce_i && state == ST_POLL && eng_done && busy |=> state == ST_POLL)
    else $error("left polling while flash busy");
  AST_WREN_FIRST: assert property (
    $rose(state == ST_OP) && cmd.op != CMD_WRITE_STATUS
    |-> $past(state) == ST_WREN)
    else $error("erase or program without write enable");
  AST_STRAP_HOLD: assert property (
    state != ST_STRAP && !boot_rst && !$past(boot_rst) |=> $stable(slave_mode))
    else $error("boot mode changed without reset");
  AST_DFU_GATE: assert property (
    cmd_ready_o |-> flash_ok && state == ST_IDLE)
    else $error("command accepted without flash");
endmodule

// >>> core/bfs_pkg.sv
// bfs_pkg: constants and carrier types of the boot flash sequencer
// assumes: one 20 MHz clock domain, byte-wide image stream
package bfs_pkg;
  localparam int PAGE_BYTES = 256;
  localparam int PAGE_COUNT = 8192;
  localparam logic [24:0] FLASH_BYTES = 25'(PAGE_BYTES * PAGE_COUNT);
  localparam int ADDR_BYTES = 3;
  localparam int ID_BYTES = 3;
  localparam int QREAD_DUMMY_BYTES = 1;
  localparam logic [7:0] OP_READ_ID = 8'h9F;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_WRITE_EN = 8'h06;
  localparam logic [7:0] OP_WRITE_DIS = 8'h04;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_QUAD_READ = 8'hEB;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] STATUS_BUSY_MASK = 8'h01;
  // uniform 4 kB sectors
  localparam logic [23:0] SECTOR_MASK = 24'hFF_F000;
  localparam logic [23:0] DIR_ADDR = 24'h00_0000;
  localparam logic [23:0] FACTORY_BASE = 24'h00_1000;
  localparam logic [23:0] UPGRADE_BASE = 24'h10_0000;
  localparam logic [7:0] UPGRADE_MARK = 8'hA5;
  localparam logic [23:0] ID_BLANK = 24'hFF_FFFF;
  localparam logic [2:0] SCK_HIGH_PHASE = 3'h4;
  localparam logic [2:0] BEAT_END_PHASE = 3'h7;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W = 17;

  typedef enum logic [1:0] {
    CMD_ERASE,
    CMD_PROGRAM,
    CMD_WRITE_STATUS,
    CMD_REMOVE
  } bfs_cmd_op_type;

  typedef struct packed {
    bfs_cmd_op_type op;
    logic [23:0] addr;
    logic [7:0] data;
  } bfs_cmd_type;

  typedef struct packed {
    logic [7:0] op;
    logic addr_en;
    logic [23:0] addr;
    logic quad;
    logic dummy;
    logic tx_en;
    logic [7:0] tx;
    logic [CNT_W-1:0] count;
  } bfs_xfer_type;

  typedef struct packed {
    logic boot_done;
    logic slave_mode;
    logic upgrade_image;
    logic flash_ok;
    logic overrun;
  } bfs_status_type;
endpackage

// >>> core/bfs_fifo.sv
// bfs_fifo: flip-flop FIFO with valid and ready on both sides
// assumes: one clock, synchronous active-high reset, clock enable
`timescale 1ns/10ps
module bfs_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock, reset, enable
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_idx;
  logic [AW-1:0] rd_idx;
  logic [AW:0] fill;
  wire logic push = in_valid_i && in_ready_o;
  wire logic pop = out_valid_o && out_ready_i;

  assign in_ready_o = (fill != (AW+1)'(DEPTH));
  assign out_valid_o = (fill != '0);
  assign out_data_o = mem[rd_idx];

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      wr_idx <= '0;
      rd_idx <= '0;
      fill <= '0;
    end else if (ce_i) begin
      if (push) begin
        wr_idx <= (wr_idx == AW'(DEPTH - 1)) ? '0 : wr_idx + 1'b1;
      end
      if (pop) begin
        rd_idx <= (rd_idx == AW'(DEPTH - 1)) ? '0 : rd_idx + 1'b1;
      end
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge clock_i) begin
    if (ce_i && push) begin
      mem[wr_idx] <= in_data_i;
    end
  end
endmodule

// >>> sim/bfs_flash_model.sv
// bfs_flash_model: behavioural quad flash facing bfs_top
// assumes: master shifts on clock low, samples on clock high
`timescale 1ns/10ps
module bfs_flash_model
  import bfs_pkg::*;
#(
  parameter logic [23:0] ID = 24'h00_0001
) (
  // link from the master
  input wire logic clk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] dev_i,
  input wire logic [3:0] dev_oe_n_i,
  // strap pull and resolved pins
  input wire logic strap_i,
  output logic [3:0] pin_o
);
  logic [3:0] v = 4'h0;
  logic drv = 1'b0;
  logic wel = 1'b0;
  logic [7:0] dir = 8'h00;
  logic [7:0] sreg = 8'h00;
  logic [31:0] sh = 32'h0000_0000;
  logic [23:0] a = 24'h00_0000;
  int busy = 0;
  // released lines: line 1 at the strap pull, the rest flipped
  wire [3:0] mv = drv ? v : {~v[3:2], strap_i, ~v[0]};
  assign pin_o = (dev_i & ~dev_oe_n_i) | (mv & dev_oe_n_i);
  task automatic rx(input int n, input bit q);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      sh = q ? {sh[27:0], pin_o} : {sh[30:0], pin_o[0]};
      if (q && i[0]) sh[7:0] = {sh[3:0], sh[7:4]};
    end
  endtask
  task automatic tx(input logic [7:0] b, input bit q);
    for (int i = 0; i < (q ? 2 : 8); i++) begin
      @(negedge clk_i);
      drv = 1'b1;
      v = q ? b[4*i +: 4] : {2'b00, b[7-i], 1'b0};
    end
  endtask
  task automatic serve();
    logic [7:0] op;
    rx(8, 1'b0);
    op = sh[7:0];
    case (op)
      OP_READ_ID: for (int k = 2; k >= 0; k--) tx(ID[8*k +: 8], 1'b0);
      OP_WRITE_EN: wel = 1'b1;
      OP_WRITE_DIS: wel = 1'b0;
      OP_WRITE_STATUS: begin
        rx(8, 1'b0);
        sreg = sh[7:0];
      end
      OP_READ_STATUS: forever begin
        tx({7'h00, busy > 0}, 1'b0);
        busy--;
      end
      OP_SECTOR_ERASE, OP_PAGE_PROG: begin
        rx(op == OP_PAGE_PROG ? 32 : 24, 1'b0);
        // writes without the latch set are ignored
        if (wel && op == OP_PAGE_PROG && sh[31:8] == DIR_ADDR)
          dir = sh[7:0];
        if (wel && op == OP_SECTOR_ERASE && (sh[23:0] & SECTOR_MASK) == 0)
          dir = 8'hFF;
        wel = 1'b0;
        busy = 3;
      end
      OP_QUAD_READ: begin
        rx(6, 1'b1);
        a = sh[23:0];
        rx(2, 1'b1);
        forever begin
          tx(a == DIR_ADDR ? dir : {a[20], a[6:0]}, 1'b1);
          a++;
        end
      end
      default: ;
    endcase
    // hold the last driven bit until the master lets the select go
    @(posedge cs_n_i);
  endtask
  initial forever begin
    @(negedge cs_n_i);
    fork
      serve();
      @(posedge cs_n_i);
    join_any
    disable fork;
    drv = 1'b0;
  end
endmodule

// >>> sim/bfs_top_tb_top.sv
// bfs_top_tb_top: self-checking bench for bfs_top
// assumes: flash model on the flash link; host serial link driven here
`timescale 1ns/10ps
module bfs_top_tb_top;
  import bfs_pkg::*;
  localparam int NB = 24;
  // arbitrary identifier value
  localparam logic [23:0] FLASH_ID = 24'h5A_3C01;
  logic clock_i = 1'b0, rst_i = 1'b1, sup = 1'b1, pin_n = 1'b1;
  logic strap = 1'b0, sck = 1'b0, scs_n = 1'b1, mosi = 1'b0;
  logic cmd_valid = 1'b0, ready = 1'b0, stall = 1'b1;
  bfs_cmd_type cmd = '0;
  wire fclk, fcs_n, cmd_rdy, ivalid, miso;
  wire [3:0] fo, foe_n, fi;
  wire [7:0] idata;
  wire [23:0] id;
  bfs_status_type st;
  int fail_count = 0;
  int cmp_count = 0;
  logic [7:0] exp_q[$];
  always #25 clock_i = ~clock_i;
  bfs_top #(.IMAGE_BYTES(NB)) dut_u (
    .clock_i(clock_i), .rst_i(rst_i), .ce_i(1'b1),
    .supply_good_i(sup), .reset_pin_n_i(pin_n),
    .flash_clk_o(fclk), .flash_cs_n_o(fcs_n),
    .flash_data_line_0_i(fi[0]), .flash_data_line_1_i(fi[1]),
    .flash_data_line_2_i(fi[2]), .flash_data_line_3_i(fi[3]),
    .flash_data_line_0_o(fo[0]), .flash_data_line_1_o(fo[1]),
    .flash_data_line_2_o(fo[2]), .flash_data_line_3_o(fo[3]),
    .flash_data_line_0_oe_n_o(foe_n[0]),
    .flash_data_line_1_oe_n_o(foe_n[1]),
    .flash_data_line_2_oe_n_o(foe_n[2]),
    .flash_data_line_3_oe_n_o(foe_n[3]),
    .spi_clk_i(sck), .spi_cs_n_i(scs_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
    .cmd_valid_i(cmd_valid), .cmd_i(cmd), .cmd_ready_o(cmd_rdy),
    .image_valid_o(ivalid), .image_data_o(idata), .image_ready_i(ready),
    .status_o(st), .flash_id_o(id)
  );
  bfs_flash_model #(.ID(FLASH_ID)) flash_u (
    .clk_i(fclk), .cs_n_i(fcs_n), .dev_i(fo), .dev_oe_n_i(foe_n),
    .strap_i(strap), .pin_o(fi)
  );
  task automatic chk(input string n, input logic [23:0] e, g);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  always @(negedge clock_i) ready <= !stall && ($urandom % 4 != 0);
  always @(posedge clock_i) if (ivalid === 1'b1 && ready) begin
    if (exp_q.size() == 0) chk("extra", 24'hFF_FFFF, 24'(idata));
    else chk("byte", 24'(exp_q.pop_front()), 24'(idata));
  end
  task automatic wait_rdy();
    for (int i = 0; i < 20000 && cmd_rdy !== 1'b1; i++) @(negedge clock_i);
    chk("ready", 24'h1, 24'(cmd_rdy));
  endtask
  task automatic send(input bfs_cmd_op_type o, input logic [7:0] d);
    wait_rdy();
    cmd = '{o, DIR_ADDR, d};
    cmd_valid = 1'b1;
    @(negedge clock_i);
    cmd_valid = 1'b0;
    repeat (2) @(negedge clock_i);
    wait_rdy();
  endtask
  task automatic reboot(input bit por, input logic s, input logic [23:0] b);
    strap = s;
    if (por) sup = 1'b0;
    else pin_n = 1'b0;
    repeat (4) @(negedge clock_i);
    sup = 1'b1;
    pin_n = 1'b1;
    for (int i = 0; i < NB && !s; i++) exp_q.push_back({b[20], 7'(i)});
  endtask
  task automatic drain();
    for (int i = 0; i < 20000 && exp_q.size() > 0; i++) @(negedge clock_i);
    chk("left", 24'h0, 24'(exp_q.size()));
  endtask
  task automatic spi_byte(input logic [7:0] b);
    exp_q.push_back(b);
    for (int i = 0; i < 8; i++) begin
      mosi = b[i];
      #200 sck = 1'b1;
      #200 sck = 1'b0;
    end
  endtask
  initial begin
    void'($urandom(5));
    repeat (16) @(negedge clock_i);
    rst_i = 1'b0;
    reboot(1'b0, 1'b0, FACTORY_BASE);
    // consumer held off so the buffer fills and the reader stalls
    repeat (1500) @(negedge clock_i);
    stall = 1'b0;
    drain();
    chk("id", FLASH_ID, id);
    send(CMD_PROGRAM, UPGRADE_MARK);
    send(CMD_WRITE_STATUS, 8'h5C);
    chk("sreg", 24'h5C, 24'(flash_u.sreg));
    chk("done", 24'h3, 24'({st.boot_done, st.flash_ok}));
    reboot(1'b0, 1'b0, UPGRADE_BASE);
    drain();
    chk("upg", 24'h3, 24'({st.upgrade_image, st.flash_ok}));
    send(CMD_REMOVE, 8'h00);
    reboot(1'b1, 1'b0, FACTORY_BASE);
    drain();
    reboot(1'b0, 1'b1, FACTORY_BASE);
    repeat (20) @(negedge clock_i);
    strap = 1'b0;
    #7 scs_n = 1'b0;
    for (int k = 0; k < 20; k++) spi_byte(8'($urandom));
    #200 scs_n = 1'b1;
    drain();
    repeat (8) @(negedge clock_i);
    chk("stat", 24'h4, 24'({st.boot_done, st.overrun, miso}));
    chk("slave", 24'h2, 24'({st.slave_mode, cmd_rdy}));
    end_of_test();
  end
  initial begin
    #(60000 * 50);
    fail_count++;
    end_of_test();
  end
endmodule
